// File: cgc_pkg.sv
// constants and types for the clock generator control block
package cgc_pkg;
   localparam int         CGC_W             = 8;
   // standby/clock control register layout
   localparam int         CGC_HALT_BIT      = 0;
   localparam int         CGC_STOP_BIT      = 1;
   localparam int         CGC_DIV_LO_BIT    = 4;
   localparam int         CGC_DIV_HI_BIT    = 5;
   localparam logic [7:0] CGC_CTRL_RESET    = 8'h30;
   localparam logic [7:0] CGC_CTRL_MASK     = 8'h33;
   // oscillator mode register layout
   localparam int         CGC_EXT_SEL_BIT   = 7;
   localparam logic [7:0] CGC_MODE_RESET    = 8'h00;
   // divide ratio codes (ratio = 2 << code)
   localparam logic [1:0] CGC_DIV2          = 2'h0;
   localparam logic [1:0] CGC_DIV16         = 2'h3;
   // longest switch time per previous ratio, in oscillator periods
   localparam int         CGC_SW_MAX_DIV2   = 22;
   localparam int         CGC_SW_MAX_DIV4   = 24;
   localparam int         CGC_SW_MAX_DIV8   = 16;
   localparam int         CGC_SW_MAX_DIV16  = 16;
   localparam int         CGC_ADDR_W        = 20;

   typedef enum logic [1:0] {
      CGC_WR_MOV8  = 2'h0,
      CGC_WR_MOVR  = 2'h1,
      CGC_WR_LOGIC = 2'h2,
      CGC_WR_BIT   = 2'h3
   } cgc_wr_kind_e;

   typedef enum logic [1:0] {
      CGC_RUN    = 2'h0,
      CGC_SWITCH = 2'h1,
      CGC_STOPPED = 2'h3
   } cgc_state_e;
endpackage

// File: cgc_clock_control.sv
// clock generator control: protected divider control, oscillator mode, divider
`timescale 1ns/1ps
module cgc_clock_control
   import cgc_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  ded_wr,
   input  wire logic [7:0]            ded_byte3,
   input  wire logic [7:0]            ded_byte4,
   input  wire logic [CGC_ADDR_W-1:0] ded_pc,
   input  wire logic                  sfr_wr,
   input  wire logic                  sfr_sel_mode,
   input  wire cgc_wr_kind_e          sfr_kind,
   input  wire logic [7:0]            sfr_wdata,
   input  wire logic                  stop_release,
   output logic [7:0]                 standby_clock_divider_control,
   output logic [7:0]                 oscillator_mode_select,
   output logic                       op_error,
   output logic [CGC_ADDR_W-1:0]      op_error_ret_addr,
   output logic                       sys_clk_en,
   output logic                       osc_run,
   output logic                       osc_src_return,
   output logic [1:0]                 div_active
);
   cgc_state_e            state, next_state;
   logic [7:0]            next_ctrl, next_mode;
   logic                  next_op_error;
   logic [CGC_ADDR_W-1:0] next_ret_addr;
   logic [3:0]            cnt, next_cnt;
   logic [1:0]            next_div_active;
   logic [3:0]            last;
   logic                  wrap;
   logic                  ded_ok;

   // terminal count of the ratio now in use
   assign last   = 4'((5'h2 << div_active) - 5'h1);
   assign wrap   = (cnt == last);
   assign ded_ok = (ded_byte3 == ~ded_byte4);

   // register writes
   always_comb begin
      next_ctrl     = standby_clock_divider_control;
      next_mode     = oscillator_mode_select;
      next_op_error = 1'b0;
      next_ret_addr = op_error_ret_addr;
      if (ded_wr && ded_ok) begin
         next_ctrl = ded_byte4 & CGC_CTRL_MASK;
      end
      if (ded_wr && !ded_ok) begin
         next_op_error = 1'b1;
         next_ret_addr = ded_pc;
      end
      // stop wake clears stop; a same-cycle dedicated set wins
      if (stop_release && !(ded_wr && ded_ok && ded_byte4[CGC_STOP_BIT])) begin
         next_ctrl[CGC_STOP_BIT] = 1'b0;
      end
      if (sfr_wr && sfr_sel_mode && sfr_kind == CGC_WR_MOV8) begin
         next_mode = sfr_wdata;
      end
      // ordinary writes to the control register are simply not decoded
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         standby_clock_divider_control <= CGC_CTRL_RESET;
         oscillator_mode_select        <= CGC_MODE_RESET;
         op_error                      <= 1'b0;
         op_error_ret_addr             <= '0;
      end else begin
         standby_clock_divider_control <= next_ctrl;
         oscillator_mode_select        <= next_mode;
         op_error                      <= next_op_error;
         op_error_ret_addr             <= next_ret_addr;
      end
   end

   // divider and ratio switch
   always_comb begin
      next_state      = state;
      next_cnt        = cnt;
      next_div_active = div_active;
      sys_clk_en      = 1'b0;
      case (state)
         CGC_RUN, CGC_SWITCH: begin
            sys_clk_en = wrap;
            next_cnt   = wrap ? 4'h0 : cnt + 4'h1;
            // ratio swaps only at a period boundary
            if (wrap) begin
               next_div_active = standby_clock_divider_control[CGC_DIV_HI_BIT:CGC_DIV_LO_BIT];
               next_state      = CGC_RUN;
            end else if (standby_clock_divider_control[CGC_DIV_HI_BIT:CGC_DIV_LO_BIT]
                         != div_active) begin
               next_state = CGC_SWITCH;
            end
            if (standby_clock_divider_control[CGC_STOP_BIT]) begin
               next_state = CGC_STOPPED;
               next_cnt   = 4'h0;
            end
         end
         CGC_STOPPED: begin
            next_cnt = 4'h0;
            if (!standby_clock_divider_control[CGC_STOP_BIT]) begin
               next_state      = CGC_RUN;
               next_div_active = standby_clock_divider_control[CGC_DIV_HI_BIT:CGC_DIV_LO_BIT];
            end
         end
         default: begin
            next_state = CGC_RUN;
            next_cnt   = 4'h0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state      <= CGC_RUN;
         cnt        <= 4'h0;
         div_active <= CGC_DIV16;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         div_active <= next_div_active;
      end
   end

   // resonator runs only when not stopped and not in external mode
   assign osc_run = !standby_clock_divider_control[CGC_STOP_BIT]
                    && !oscillator_mode_select[CGC_EXT_SEL_BIT];
   // return pin feeds internal clock in external mode
   assign osc_src_return = oscillator_mode_select[CGC_EXT_SEL_BIT];

   // switch-time helper: periods since a ratio request went pending
   logic [5:0] sw_age;
   logic [1:0] sw_prev;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_age  <= 6'h0;
         sw_prev <= CGC_DIV16;
      end else if (state == CGC_SWITCH) begin
         sw_age <= sw_age + 6'h1;
      end else begin
         sw_age  <= 6'h0;
         sw_prev <= div_active;
      end
   end

   a_switch_bound: assert property (@(posedge clk) disable iff (!rst_b)
      state == CGC_SWITCH |-> sw_age < 6'(sw_prev == CGC_DIV2 ? CGC_SW_MAX_DIV2 :
         sw_prev == 2'h1 ? CGC_SW_MAX_DIV4 :
         sw_prev == 2'h2 ? CGC_SW_MAX_DIV8 : CGC_SW_MAX_DIV16))
      else $error("ratio switch too slow");
   a_ded_write_load: assert property (@(posedge clk) disable iff (!rst_b)
      ded_wr && ded_ok && !stop_release |=> standby_clock_divider_control
         == ($past(ded_byte4) & CGC_CTRL_MASK))
      else $error("dedicated write not applied");
   a_bad_write_error: assert property (@(posedge clk) disable iff (!rst_b)
      ded_wr && !ded_ok && !stop_release |=> op_error
         && $stable(standby_clock_divider_control))
      else $error("bad dedicated write mishandled");
   a_error_ret_addr: assert property (@(posedge clk) disable iff (!rst_b)
      ded_wr && !ded_ok |=> op_error_ret_addr == $past(ded_pc))
      else $error("wrong return address");
   // no error without a bad write
   a_error_cause: assert property (@(posedge clk) disable iff (!rst_b)
      op_error |-> $past(ded_wr) && !$past(ded_ok))
      else $error("spurious operand error");
   a_plain_write_ignored: assert property (@(posedge clk) disable iff (!rst_b)
      !ded_wr && !stop_release |=> $stable(standby_clock_divider_control))
      else $error("control register changed by plain write");
   a_mode_kind_gate: assert property (@(posedge clk) disable iff (!rst_b)
      sfr_wr && sfr_sel_mode && sfr_kind != CGC_WR_MOV8 |=> $stable(oscillator_mode_select))
      else $error("mode register written by wrong kind");
   a_div_period: assert property (@(posedge clk) disable iff (!rst_b)
      sys_clk_en && state == CGC_RUN && div_active == CGC_DIV2 &&
         standby_clock_divider_control[CGC_DIV_HI_BIT:CGC_DIV_LO_BIT] == CGC_DIV2
         && !standby_clock_divider_control[CGC_STOP_BIT]
         ##1 !standby_clock_divider_control[CGC_STOP_BIT]
         |-> ##1 sys_clk_en)
      else $error("divide by two spacing wrong");
   a_stop_no_clock: assert property (@(posedge clk) disable iff (!rst_b)
      state == CGC_STOPPED |-> !sys_clk_en)
      else $error("clock running in stop");
   // oscillator off whenever stop is set, the wake cycle included; it may run again once stop clears
   a_stop_osc_off: assert property (@(posedge clk) disable iff (!rst_b)
      standby_clock_divider_control[CGC_STOP_BIT] |-> !osc_run)
      else $error("oscillator running in stop");

   c_good_write:   cover property (@(posedge clk) disable iff (!rst_b) ded_wr && ded_ok);
   c_bad_write:    cover property (@(posedge clk) disable iff (!rst_b) op_error);
   c_ratio_switch: cover property (@(posedge clk) disable iff (!rst_b)
      state == CGC_SWITCH ##[1:20] state == CGC_RUN);
   c_stop_wake:    cover property (@(posedge clk) disable iff (!rst_b)
      state == CGC_STOPPED ##[1:50] state == CGC_RUN);
endmodule // cgc_clock_control

// File: cgc_osc_source.sv
// behavioural external clock source driving both oscillator pins
`timescale 1ns/1ps
module cgc_osc_source (
   input  wire logic ref_clk,
   output logic      osc_input_pin,
   output logic      osc_return_pin
);
   // clock plus inverse
   // runs free: an external oscillator has no frames to stop between
   assign osc_input_pin  = ref_clk;
   assign osc_return_pin = ~ref_clk;
endmodule // cgc_osc_source

// File: test_clock_generator_control.sv
// self-checking bench for the clock generator control block
`timescale 1ns/1ps
module test_clock_generator_control
   import cgc_pkg::*;
;
   typedef struct packed {
      logic [7:0] b3;
      logic [7:0] b4;
      logic [7:0] ctrl;
      logic       err;
   } cgc_row_s;
   logic                  clk = 1'b0, rst_b = 1'b0, ded_wr = 1'b0, sfr_wr = 1'b0;
   logic                  sel = 1'b0, rel = 1'b0, seen = 1'b0;
   logic [7:0]            b3 = 8'h00, b4 = 8'h00, wd = 8'h00, ctrl, mode;
   logic [CGC_ADDR_W-1:0] pc = '0, ret;
   cgc_wr_kind_e          kind = CGC_WR_MOV8;
   logic                  err, en, run, src, pin_in, pin_ret;
   logic [1:0]            div;
   int                    bad_count = 0, total_checks = 0, n;
   int                    sw [4] = '{CGC_SW_MAX_DIV16, CGC_SW_MAX_DIV2, CGC_SW_MAX_DIV4,
                                     CGC_SW_MAX_DIV8};
   // third byte, fourth byte, expected register, expected error
   cgc_row_s              rows [6] = '{'{8'hff, 8'h00, 8'h00, 1'b0},
      '{8'hef, 8'h10, 8'h10, 1'b0}, '{8'h00, 8'h10, 8'h10, 1'b1},
      '{8'hde, 8'h21, 8'h21, 1'b0}, '{8'h33, 8'hcc, 8'h00, 1'b0},
      '{8'hcf, 8'h30, 8'h30, 1'b0}};
   always #4 clk = ~clk;
   cgc_osc_source i_src (.ref_clk(clk), .osc_input_pin(pin_in), .osc_return_pin(pin_ret));
   cgc_clock_control i_dut (.clk(pin_in), .rst_b(rst_b), .ded_wr(ded_wr), .ded_byte3(b3),
      .ded_byte4(b4), .ded_pc(pc), .sfr_wr(sfr_wr), .sfr_sel_mode(sel), .sfr_kind(kind),
      .sfr_wdata(wd), .stop_release(rel), .standby_clock_divider_control(ctrl),
      .oscillator_mode_select(mode), .op_error(err), .op_error_ret_addr(ret),
      .sys_clk_en(en), .osc_run(run), .osc_src_return(src), .div_active(div));
   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // error pulses in the first cycle after the write and clears in the next; both following cycles are watched
   task automatic ded(input logic [7:0] t3, input logic [7:0] t4);
      @(negedge clk);
      ded_wr = 1'b1;
      b3 = t3;
      b4 = t4;
      pc = pc + 20'h4;
      @(negedge clk);
      ded_wr = 1'b0;
      seen = err;
      @(negedge clk);
      seen = seen | err;
   endtask
   task automatic sfr(input logic s, input cgc_wr_kind_e k, input logic [7:0] d);
      @(negedge clk);
      sfr_wr = 1'b1;
      sel = s;
      kind = k;
      wd = d;
      @(negedge clk);
      sfr_wr = 1'b0;
      seen = err;
      @(negedge clk);
      seen = seen | err;
   endtask
   task automatic conclude();
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      chk("control", 20'(CGC_CTRL_RESET), 20'(ctrl));
      chk("mode", 20'(CGC_MODE_RESET), 20'(mode));
      chk("ratio", 20'(CGC_DIV16), 20'(div));
      chk("osc_run", 20'h1, 20'(run));
      @(negedge clk);
      rst_b = 1'b1;
      foreach (rows[i]) begin
         ded(rows[i].b3, rows[i].b4);
         chk("control", 20'(rows[i].ctrl), 20'(ctrl));
         chk("op_error", 20'(rows[i].err), 20'(seen));
         if (rows[i].err) chk("ret_addr", pc, ret);
      end
      for (int k = 0; k < 4; k++) begin
         sfr(1'b0, cgc_wr_kind_e'(k), 8'h02);
         chk("control", 20'h30, 20'(ctrl));
         chk("op_error", 20'h0, 20'(seen));
      end
      for (int k = 3; k >= 0; k--) begin
         sfr(1'b1, cgc_wr_kind_e'(k), 8'h80);
         chk("mode", (k == 0) ? 20'h80 : 20'h0, 20'(mode));
      end
      chk("return_src", 20'h1, 20'(src));
      for (int c = 0; c < 4; c++) begin
         ded(~(8'(c) << 4), 8'(c) << 4);
         n = 0;
         while (div !== 2'(c) && n < 40) begin
            @(negedge clk);
            n++;
         end
         chk("switch_ok", 20'h1, 20'(n < sw[c]));
         for (int i = 0; i < 40 && en !== 1'b1; i++) @(negedge clk);
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (en !== 1'b1 && n < 40);
         chk("period", 20'(2 << c), 20'(n));
      end
      // mode bit already set before stop, as external clock use demands
      ded(8'hcd, 8'h32);
      n = 0;
      repeat (20) begin
         @(negedge clk);
         n = n + int'(en === 1'b1);
      end
      chk("osc_run", 20'h0, 20'(run));
      chk("stop_ticks", 20'h0, 20'(n));
      rel = 1'b1;
      @(negedge clk);
      rel = 1'b0;
      @(negedge clk);
      chk("control", 20'h30, 20'(ctrl));
      for (int i = 0; i < 40 && en !== 1'b1; i++) @(negedge clk);
      chk("wake_tick", 20'h1, 20'(en));
      // back to resonator mode: oscillator on, internal clock off the return pin
      sfr(1'b1, CGC_WR_MOV8, 8'h00);
      chk("osc_run", 20'h1, 20'(run));
      chk("return_src", 20'h0, 20'(src));
      // move the control, mode and ratio registers off their reset values, then reset in mid-run
      ded(8'hff, 8'h00);
      sfr(1'b1, CGC_WR_MOV8, 8'h80);
      repeat (20) @(negedge clk);
      chk("ratio", 20'(CGC_DIV2), 20'(div));
      rst_b = 1'b0;
      @(negedge clk);
      chk("control", 20'(CGC_CTRL_RESET), 20'(ctrl));
      chk("mode", 20'(CGC_MODE_RESET), 20'(mode));
      chk("ratio", 20'(CGC_DIV16), 20'(div));
      rst_b = 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (en !== 1'b1 && n < 40);
      // tick taken at the 16th edge, seen half a cycle before it
      chk("first_tick", 20'(2 << CGC_DIV16) - 20'h1, 20'(n));
      conclude();
   end
   initial begin
      #80000;
      bad_count++;
      conclude();
   end
endmodule // test_clock_generator_control
